// [include/e1bis_pkg.sv]
// Package with offsets, bit positions and reset values of the E1 block status logic
package e1bis_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int IDX_W  = 12;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register indices (Avalon word address)
   localparam logic [IDX_W-1:0] OFS_CLK_CTRL     = 12'h100;
   localparam logic [IDX_W-1:0] OFS_FCS3_CNT     = 12'h91D;
   localparam logic [IDX_W-1:0] OFS_BLOCK_SUM    = 12'hB00;
   localparam logic [IDX_W-1:0] OFS_ALARM_STAT0  = 12'hB02;
   localparam logic [IDX_W-1:0] OFS_FRAMER_STAT  = 12'hB04;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT0   = 12'hB06;
   localparam logic [IDX_W-1:0] OFS_SLIP_STAT    = 12'hB08;
   localparam logic [IDX_W-1:0] OFS_NAT6_STAT    = 12'hB0C;
   localparam logic [IDX_W-1:0] OFS_ALARM_STAT1  = 12'hB0E;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT3   = 12'hB10;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT1   = 12'hB16;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT4   = 12'hB18;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT2   = 12'hB26;
   localparam logic [IDX_W-1:0] OFS_HDLC_STAT5   = 12'hB28;
   localparam logic [IDX_W-1:0] OFS_ALARM_STAT2  = 12'hB40;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pending flag slots and their source status registers
   localparam int SRC_N        = 12;
   localparam int SLOT_NAT6    = 0;
   localparam int SLOT_HDLC    = 1;
   localparam int HDLC_N       = 6;
   localparam int SLOT_SLIP    = 7;
   localparam int SLOT_ALARM   = 8;
   localparam int ALARM_N      = 3;
   localparam int SLOT_FRAMER  = 11;
   localparam logic [SRC_N-1:0][IDX_W-1:0] SRC_OFS = {
      OFS_FRAMER_STAT, OFS_ALARM_STAT2, OFS_ALARM_STAT1, OFS_ALARM_STAT0, OFS_SLIP_STAT,
      OFS_HDLC_STAT5, OFS_HDLC_STAT4, OFS_HDLC_STAT3, OFS_HDLC_STAT2, OFS_HDLC_STAT1,
      OFS_HDLC_STAT0, OFS_NAT6_STAT};

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Summary bit positions and control field
   localparam int BIT_NAT6     = 7;
   localparam int BIT_RSVD     = 6;
   localparam int BIT_CLK_LOSS = 5;
   localparam int BIT_ONE_SEC  = 4;
   localparam int BIT_HDLC     = 3;
   localparam int BIT_SLIP     = 2;
   localparam int BIT_ALARM    = 1;
   localparam int BIT_FRAMER   = 0;
   localparam int BIT_LOS_EN   = 0;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  RST_FCS_CNT = 8'h00;
   localparam logic        RST_LOS_EN  = 1'b0;
   localparam logic        RST_WAIT    = 1'b1;

endpackage : e1bis_pkg

// [include/e1bis_flag_if.sv]
// Interface carrying set, clear and pending vectors of the pending flag bank
`timescale 1ns/10ps
interface e1bis_flag_if #(
   parameter int N = 12
);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] pend;

   // Flag bank side
   modport owner (input set, input clr, output pend);
   // Register side
   modport user  (output set, output clr, input pend);
endinterface : e1bis_flag_if

// [design/e1bis_flag_bank.sv]
// Bank of sticky pending flags, set by sub-block events and cleared by status reads
`timescale 1ns/10ps
module e1bis_flag_bank #(
   parameter int N = 12
) (
   // Clock and reset
   input  wire logic    clk_in,
   input  wire logic    sys_rst_in,
   // Flag carrier
   e1bis_flag_if.owner  flg
);

   typedef struct packed {
      logic [N-1:0] pend;
   } e1bis_bank_t;

   e1bis_bank_t s_q;
   e1bis_bank_t s_d;
   logic [N-1:0] nxt;

   // Per slot: an event in the clearing cycle keeps the flag set
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_slot
         assign nxt[i] = flg.set[i] | (s_q.pend[i] & ~flg.clr[i]);
      end
   endgenerate

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.pend = nxt;
   end

   // State register
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flg.pend = s_q.pend;

   // A cleared flag with no new event is low afterwards
   AST_FLAG_CLEARS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (flg.clr != '0) |=> ((s_q.pend & $past(flg.clr) & ~$past(flg.set)) == '0))
      else $error("pending flag survived its clearing read");

   // An event always leaves its flag set, even while being cleared
   AST_FLAG_SET_WINS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (flg.set != '0) |=> ((s_q.pend & $past(flg.set)) == $past(flg.set)))
      else $error("pending flag lost an event");

endmodule : e1bis_flag_bank

// [design/e1bis_status_regs.sv]
// Block interrupt summary and LAPD3 error counter behind an Avalon-MM slave
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module e1bis_status_regs #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input  wire logic                            clk_in,
   input  wire logic                            sys_rst_in,
   // Avalon-MM slave
   input  wire logic [e1bis_pkg::IDX_W-1:0]     avs_address_in,
   input  wire logic                            avs_read_in,
   input  wire logic                            avs_write_in,
   input  wire logic [e1bis_pkg::DATA_W-1:0]    avs_writedata_in,
   input  wire logic [e1bis_pkg::BE_W-1:0]      avs_byteenable_in,
   output logic      [e1bis_pkg::DATA_W-1:0]    avs_readdata_out,
   output logic                                 avs_waitrequest_out,
   // Sub-block request events, one-cycle pulses
   input  wire logic                            nat6_event_in,
   input  wire logic [e1bis_pkg::HDLC_N-1:0]    hdlc_event_in,
   input  wire logic                            slip_event_in,
   input  wire logic [e1bis_pkg::ALARM_N-1:0]   alarm_event_in,
   input  wire logic                            framer_event_in,
   // Framer declarations and LAPD3 error pulse
   input  wire logic                            clk_loss_in,
   input  wire logic                            one_sec_in,
   input  wire logic                            fcs3_error_in,
   // Control and read notifications
   output logic                                 clk_loss_det_en_out,
   output logic      [e1bis_pkg::SRC_N-1:0]     src_read_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                          wait_req;
      logic [e1bis_pkg::DATA_W-1:0]  rdata;
      logic [CNT_W-1:0]              cnt;
      logic                          los_en;
      logic [e1bis_pkg::SRC_N-1:0]   src_rd;
   } e1bis_regs_t;

   e1bis_regs_t s_q;
   e1bis_regs_t s_d;

   e1bis_flag_if #(.N(e1bis_pkg::SRC_N)) flg ();

   logic                          req;
   logic                          done;
   logic [e1bis_pkg::SRC_N-1:0]   src_hit;
   logic [e1bis_pkg::SRC_N-1:0]   pend_now;
   logic [7:0]                    summary;
   logic [CNT_W-1:0]              cnt_inc;
   logic [CNT_W-1:0]              cnt_nxt;
   logic [e1bis_pkg::DATA_W-1:0]  rd_value;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Flag bank

   e1bis_flag_bank #(
      .N          (e1bis_pkg::SRC_N)
   ) u_flags (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .flg        (flg.owner)
   );

   // Event pulses into their slots
   assign flg.set = {framer_event_in, alarm_event_in, slip_event_in, hdlc_event_in, nat6_event_in};

   // Source status register decode
   genvar i;
   generate
      for (i = 0; i < e1bis_pkg::SRC_N; i++) begin : g_src
         assign src_hit[i] = (avs_address_in == e1bis_pkg::SRC_OFS[i]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Handshake and summary

   // A request is served in two cycles: answer, then completion edge
   assign req  = avs_read_in | avs_write_in;
   assign done = req & ~s_q.wait_req;

   // Reading a source status register clears the slots it raised
   assign flg.clr = (done & avs_read_in) ? src_hit : '0;

   // Flags seen by the summary include events of this cycle
   assign pend_now = flg.pend | flg.set;

   // Summary byte as software reads it
   always_comb begin
      summary = 8'h00;
      summary[e1bis_pkg::BIT_NAT6]     = pend_now[e1bis_pkg::SLOT_NAT6];
      summary[e1bis_pkg::BIT_RSVD]     = 1'b0;
      summary[e1bis_pkg::BIT_CLK_LOSS] = clk_loss_in & s_q.los_en;
      summary[e1bis_pkg::BIT_ONE_SEC]  = one_sec_in;
      summary[e1bis_pkg::BIT_HDLC]     = |pend_now[e1bis_pkg::SLOT_HDLC +: e1bis_pkg::HDLC_N];
      summary[e1bis_pkg::BIT_SLIP]     = pend_now[e1bis_pkg::SLOT_SLIP];
      summary[e1bis_pkg::BIT_ALARM]    = |pend_now[e1bis_pkg::SLOT_ALARM +: e1bis_pkg::ALARM_N];
      summary[e1bis_pkg::BIT_FRAMER]   = pend_now[e1bis_pkg::SLOT_FRAMER];
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Counter and read mux

   // Saturating increment so a flood of errors never wraps to a small value
   assign cnt_inc = (s_q.cnt == {CNT_W{1'b1}}) ? s_q.cnt : s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
   assign cnt_nxt = fcs3_error_in ? cnt_inc : s_q.cnt;

   // Read data snapshot includes an error of this very cycle
   always_comb begin
      rd_value = '0;
      unique case (avs_address_in)
         e1bis_pkg::OFS_FCS3_CNT:  rd_value[CNT_W-1:0]            = cnt_nxt;
         e1bis_pkg::OFS_BLOCK_SUM: rd_value[7:0]                  = summary;
         e1bis_pkg::OFS_CLK_CTRL:  rd_value[e1bis_pkg::BIT_LOS_EN] = s_q.los_en;
         default:                  rd_value                       = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d        = s_q;
      s_d.src_rd = '0;
      s_d.cnt    = cnt_nxt;
      if (req & s_q.wait_req) begin
         // Answer cycle: drop waitrequest with the data ready
         s_d.wait_req = 1'b0;
         s_d.rdata    = avs_read_in ? rd_value : '0;
      end else if (done) begin
         // Completion edge: side effects happen here and only here
         s_d.wait_req = 1'b1;
         if (avs_read_in) begin
            s_d.src_rd = src_hit;
            if (avs_address_in == e1bis_pkg::OFS_FCS3_CNT) begin
               // Clear on read; an error in this cycle starts the new count
               s_d.cnt = fcs3_error_in ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
            end
         end else if ((avs_address_in == e1bis_pkg::OFS_CLK_CTRL) && avs_byteenable_in[0]) begin
            s_d.los_en = avs_writedata_in[e1bis_pkg::BIT_LOS_EN];
         end
      end
   end

   // State register
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q.wait_req <= e1bis_pkg::RST_WAIT;
         s_q.rdata    <= '0;
         s_q.cnt      <= e1bis_pkg::RST_FCS_CNT[CNT_W-1:0];
         s_q.los_en   <= e1bis_pkg::RST_LOS_EN;
         s_q.src_rd   <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_out    = s_q.rdata;
   assign avs_waitrequest_out = s_q.wait_req;
   assign clk_loss_det_en_out = s_q.los_en;
   assign src_read_out        = s_q.src_rd;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence seq_sum_answer;
      $fell(s_q.wait_req) && avs_read_in && (avs_address_in == e1bis_pkg::OFS_BLOCK_SUM);
   endsequence

   sequence seq_read_done(logic [e1bis_pkg::IDX_W-1:0] ofs);
      avs_read_in && !s_q.wait_req && (avs_address_in == ofs);
   endsequence

   AST_WAIT_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (req && s_q.wait_req) |=> !s_q.wait_req ##1 s_q.wait_req)
      else $error("waitrequest did not answer in one cycle");

   AST_CNT_CLEARED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seq_read_done(e1bis_pkg::OFS_FCS3_CNT) and !fcs3_error_in) |=> (s_q.cnt == '0))
      else $error("error counter not cleared by read");

   AST_CNT_COUNTS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (fcs3_error_in && !done && (s_q.cnt != {CNT_W{1'b1}}))
      |=> (s_q.cnt == $past(s_q.cnt) + {{(CNT_W-1){1'b0}}, 1'b1}))
      else $error("error counter missed an error");

   AST_NAT6_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> (s_q.rdata[e1bis_pkg::BIT_NAT6] == $past(pend_now[e1bis_pkg::SLOT_NAT6])))
      else $error("summary bit 7 does not match pending flag");

   AST_NAT6_CLEARED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seq_read_done(e1bis_pkg::OFS_NAT6_STAT) and !nat6_event_in) |=> !flg.pend[e1bis_pkg::SLOT_NAT6])
      else $error("national bit flag not cleared by its read");

   AST_LOS_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> (s_q.rdata[e1bis_pkg::BIT_CLK_LOSS] == $past(clk_loss_in && s_q.los_en)))
      else $error("summary bit 5 does not follow clock loss");

   AST_LOS_GATED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seq_sum_answer and !$past(s_q.los_en)) |-> !s_q.rdata[e1bis_pkg::BIT_CLK_LOSS])
      else $error("clock loss shown while detection disabled");

   AST_ONE_SEC_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> (s_q.rdata[e1bis_pkg::BIT_ONE_SEC] == $past(one_sec_in)))
      else $error("summary bit 4 does not follow one-second");

   AST_HDLC_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> (s_q.rdata[e1bis_pkg::BIT_HDLC] ==
                          $past(|pend_now[e1bis_pkg::SLOT_HDLC +: e1bis_pkg::HDLC_N])))
      else $error("summary bit 3 does not match HDLC flags");

   AST_HDLC_CLEAR_HIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_read_done(e1bis_pkg::OFS_HDLC_STAT2)
      |-> flg.clr[e1bis_pkg::SLOT_HDLC + 2] ##1 s_q.src_rd[e1bis_pkg::SLOT_HDLC + 2])
      else $error("data link status read did not clear its slot");

   AST_SLIP_CLEARED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seq_read_done(e1bis_pkg::OFS_SLIP_STAT) and !slip_event_in) |=> !flg.pend[e1bis_pkg::SLOT_SLIP])
      else $error("slip flag not cleared by its read");

   AST_ALARM_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> (s_q.rdata[e1bis_pkg::BIT_ALARM] ==
                          $past(|pend_now[e1bis_pkg::SLOT_ALARM +: e1bis_pkg::ALARM_N])))
      else $error("summary bit 1 does not match alarm flags");

   AST_FRAMER_CLEARED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seq_read_done(e1bis_pkg::OFS_FRAMER_STAT) and !framer_event_in)
      |=> !flg.pend[e1bis_pkg::SLOT_FRAMER])
      else $error("framer flag not cleared by its read");

   AST_RSVD_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sum_answer |-> !s_q.rdata[e1bis_pkg::BIT_RSVD])
      else $error("reserved summary bit not zero");

endmodule : e1bis_status_regs

// [verification/tb_top.sv]
// Self-checking bench for the E1 block summary register and LAPD3 error counter
`timescale 1ns/10ps
module tb_top;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Design signals
   logic        clk_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [11:0] avs_address_in, src_read_out;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [3:0]  avs_byteenable_in;
   logic        nat6_event_in, slip_event_in, framer_event_in, clk_loss_in, one_sec_in;
   logic        fcs3_error_in, clk_loss_det_en_out;
   logic [5:0]  hdlc_event_in;
   logic [2:0]  alarm_event_in;
   // Bench state
   int          err_total, n_checks, cycles;
   logic [31:0] seed, rd;
   logic [11:0] pend;
   logic        los_en;

   e1bis_status_regs #(.CNT_W(8)) dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .nat6_event_in(nat6_event_in),
      .hdlc_event_in(hdlc_event_in), .slip_event_in(slip_event_in), .alarm_event_in(alarm_event_in),
      .framer_event_in(framer_event_in), .clk_loss_in(clk_loss_in), .one_sec_in(one_sec_in),
      .fcs3_error_in(fcs3_error_in), .clk_loss_det_en_out(clk_loss_det_en_out),
      .src_read_out(src_read_out));

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h00000000);
   endfunction : lfsr_next

   // Expected summary from pending slots and live declarations
   function automatic logic [31:0] exp_sum(input logic [11:0] p, input logic en, input logic cl,
                                           input logic os);
      logic [31:0] s;
      s = 32'h00000000;
      s[e1bis_pkg::BIT_NAT6]     = p[0];
      s[e1bis_pkg::BIT_CLK_LOSS] = cl & en;
      s[e1bis_pkg::BIT_ONE_SEC]  = os;
      s[e1bis_pkg::BIT_HDLC]     = |p[6:1];
      s[e1bis_pkg::BIT_SLIP]     = p[7];
      s[e1bis_pkg::BIT_ALARM]    = |p[10:8];
      s[e1bis_pkg::BIT_FRAMER]   = p[11];
      return s;
   endfunction : exp_sum

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%08h exp=%08h", $time, got, exp);
      end
   endtask : chk_word

   // One Avalon transfer; holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_in);
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_read_in      <= ~wr;
      avs_write_in     <= wr;
      // Only the bench's cycle ceiling ends a wait that never answers
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus

   // Pulse sub-block events for one cycle, slot order as the flag bank
   task automatic pulse_events(input logic [11:0] v);
      @(posedge clk_in);
      {framer_event_in, alarm_event_in, slip_event_in, hdlc_event_in, nat6_event_in} <= v;
      @(posedge clk_in);
      {framer_event_in, alarm_event_in, slip_event_in, hdlc_event_in, nat6_event_in} <= 12'h000;
      pend = pend | v;
   endtask : pulse_events

   // Read one source status register and check the clear notification
   task automatic read_src(input int i);
      bus(1'b0, e1bis_pkg::SRC_OFS[i], 32'h00000000, rd);
      @(posedge clk_in);
      chk_word({20'h00000, src_read_out}, 32'h1 << i);
      pend[i] = 1'b0;
   endtask : read_src

   task automatic fcs_pulses(input int n);
      repeat (n) begin
         @(posedge clk_in);
         fcs3_error_in <= 1'b1;
         @(posedge clk_in);
         fcs3_error_in <= 1'b0;
      end
   endtask : fcs_pulses

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      clk_in = 1'b0; sys_rst_in = 1'b1; avs_read_in = 1'b0; avs_write_in = 1'b0;
      avs_address_in = 12'h000; avs_writedata_in = 32'h00000000; avs_byteenable_in = 4'hF;
      {framer_event_in, alarm_event_in, slip_event_in, hdlc_event_in, nat6_event_in} = 12'h000;
      clk_loss_in = 1'b0; one_sec_in = 1'b0; fcs3_error_in = 1'b0;
      err_total = 0; n_checks = 0; cycles = 0; seed = 32'h6E4E; pend = 12'h000; los_en = 1'b0;
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;

      // Reset values, reserved bit and unmapped index
      bus(1'b0, e1bis_pkg::OFS_FCS3_CNT, 32'h0, rd);
      chk_word(rd, 32'h00000000);
      bus(1'b1, e1bis_pkg::OFS_BLOCK_SUM, 32'hFFFFFFFF, rd);
      bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
      chk_word(rd, 32'h00000000);
      bus(1'b1, 12'h7FF, 32'hFFFFFFFF, rd);
      bus(1'b0, 12'h7FF, 32'h0, rd);
      chk_word(rd, 32'h00000000);
      chk_word({31'h0, clk_loss_det_en_out}, 32'h0);
      $display("test reset done");

      // Error counter: random counts, clear on read, saturation
      for (int k = 0; k < 6; k++) begin
         seed = lfsr_next(seed);
         n = (k == 5) ? 300 : 1 + int'(seed[4:0]);
         fcs_pulses(n);
         bus(1'b0, e1bis_pkg::OFS_FCS3_CNT, 32'h0, rd);
         chk_word(rd, (n > 255) ? 32'hFF : 32'(n));
         bus(1'b0, e1bis_pkg::OFS_FCS3_CNT, 32'h0, rd);
         chk_word(rd, 32'h00000000);
      end
      // Corner: an error at the completion edge of a clearing read starts the new count
      fork
         bus(1'b0, e1bis_pkg::OFS_FCS3_CNT, 32'h0, rd);
         begin
            repeat (2) @(posedge clk_in);
            fcs3_error_in <= 1'b1;
            @(posedge clk_in);
            fcs3_error_in <= 1'b0;
         end
      join
      chk_word(rd, 32'h00000000);
      bus(1'b0, e1bis_pkg::OFS_FCS3_CNT, 32'h0, rd);
      chk_word(rd, 32'h00000001);
      $display("test counter done");

      // All slots pending, then cleared one by one
      pulse_events(12'hFFF);
      for (int i = 0; i < 12; i++) begin
         bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
         chk_word(rd, exp_sum(pend, los_en, 1'b0, 1'b0));
         read_src(i);
      end
      bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
      chk_word(rd, 32'h00000000);
      // Corner: an event at the completion edge of its clearing read keeps the flag
      pend = 12'h800;
      fork
         bus(1'b0, e1bis_pkg::OFS_FRAMER_STAT, 32'h0, rd);
         begin
            repeat (2) @(posedge clk_in);
            framer_event_in <= 1'b1;
            @(posedge clk_in);
            framer_event_in <= 1'b0;
         end
      join
      bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
      chk_word(rd, exp_sum(pend, los_en, 1'b0, 1'b0));
      read_src(11);
      $display("test ordered clear done");

      // Random events, declarations, enable changes and partial clears
      for (int k = 0; k < 25; k++) begin
         seed = lfsr_next(seed);
         if (seed[14]) begin
            bus(1'b1, e1bis_pkg::OFS_CLK_CTRL, {31'h0, seed[15]}, rd);
            los_en = seed[15];
            @(posedge clk_in);
            chk_word({31'h0, clk_loss_det_en_out}, {31'h0, los_en});
         end
         @(posedge clk_in);
         clk_loss_in <= seed[12];
         one_sec_in  <= seed[13];
         pulse_events(seed[27:16]);
         bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
         chk_word(rd, exp_sum(pend, los_en, seed[12], seed[13]));
         seed = lfsr_next(seed);
         for (int i = 0; i < 12; i++)
            if (seed[i]) read_src(i);
         bus(1'b0, e1bis_pkg::OFS_BLOCK_SUM, 32'h0, rd);
         chk_word(rd, exp_sum(pend, los_en, clk_loss_in, one_sec_in));
      end
      $display("test random done");
      complete_run();
   end
endmodule : tb_top
